// [include/flip_pkg.sv]
// Package for the four-level interrupt priority controller
// Operation
// - Six sources, four priority levels
// - Level equals upper bit then lower bit
// - Upper priority register, one bit per source
// - Vector when no equal/higher level active
// - Equal or lower requests wait for completion
// - Higher level preempts, nested service
// - Completion restores interrupted lower handler
// - Same level resolved by fixed polling order
// - Clear edge externals and timer0/1 flags
// - Enable register: global bit7, six enables
// - Upper priority register at fixed offset
package flip_pkg;
   localparam int NSRC = 6;
   localparam int NLVL = 4;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'hA8;
   localparam logic [7:0] OFS_PRIO_LOWER = 8'hB8;
   localparam logic [7:0] OFS_PRIO_UPPER = 8'hB7;
   localparam logic [7:0] OFS_FLAGS = 8'hC0;
   localparam logic [7:0] OFS_FLAG_CLEAR = 8'hC4;
   localparam logic [7:0] OFS_ACTIVE = 8'hC8;
   localparam logic [7:0] OFS_STATUS = 8'hD0;
   localparam logic [7:0] OFS_STAT_CLEAR = 8'hD4;
   localparam logic [7:0] OFS_STAT_ENABLE = 8'hD8;
   localparam int BIT_GLOBAL_EN = 7;
   localparam logic [7:0] IE_IMPL_MASK = 8'hBF;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] VEC_BASE = 8'h03;
   localparam logic [7:0] VEC_STEP = 8'h08;
   typedef struct packed {
      logic [7:0] irq_enable;
      logic [5:0] prio_lower;
      logic [5:0] prio_upper;
      logic [5:0] pend;
      logic [3:0] active;
      logic [2:0] stat;
      logic [2:0] stat_en;
      logic vec_valid;
      logic [2:0] vec_src;
      logic [7:0] vec_addr;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } flip_state_s;
   function automatic logic [1:0] flip_level(input logic [5:0] up, input logic [5:0] lo,
                                             input int i);
      flip_level = {up[i], lo[i]};
   endfunction : flip_level
endpackage : flip_pkg

// [rtl/flip_ctrl.sv]
// Four-level nested interrupt controller with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module flip_ctrl
   import flip_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sources: one-cycle set pulses; ext level inputs pass straight through
   input wire logic ext0_request_flag,
   input wire logic ext0_edge_mode,
   input wire logic ext1_request_flag,
   input wire logic ext1_edge_mode,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_overflow_flag,
   input wire logic receive_done_flag,
   input wire logic transmit_done_flag,
   input wire logic timer2_overflow_flag,
   input wire logic timer2_external_flag,
   // CPU core
   output logic vec_valid,
   output logic [7:0] vec_addr,
   output logic [2:0] vec_src,
   input wire logic vec_ack,
   input wire logic handler_done,
   // Interrupt output
   output logic irq
);
   flip_state_s st_reg, st_next;
   logic [5:0] raw_set, req, level_flags;
   logic [5:0] clr_hw;
   logic wr_fire, rd_fire, aw_hs, w_hs;
   logic [1:0] best_lvl, act_lvl;
   logic best_any, preempt_ok;
   logic [2:0] best_src;
   logic [31:0] rd_word;
   logic rd_ok;
   logic [7:0] be0;
   logic [1:0] take_lvl;

   // Set inputs; serial and timer 2 each merge two flags
   always_comb
   begin
      raw_set = {timer2_overflow_flag | timer2_external_flag,
                 receive_done_flag | transmit_done_flag,
                 timer1_overflow_flag, ext1_request_flag,
                 timer0_overflow_flag, ext0_request_flag};
      // Level-triggered externals add the pin on top of the latched flag
      level_flags = {3'b000, ~ext1_edge_mode & ext1_request_flag, 1'b0,
                     ~ext0_edge_mode & ext0_request_flag};
   end

   // Gating and arbitration
   always_comb
   begin
      req = (st_reg.pend | level_flags) & st_reg.irq_enable[5:0]
            & {NSRC{st_reg.irq_enable[BIT_GLOBAL_EN]}};
      best_any = 1'b0;
      best_lvl = 2'd0;
      best_src = 3'd0;
      // Ascending scan with strict compare keeps the earliest source on ties
      for (int i = 0; i < NSRC; i++)
      begin
         if (req[i] && (!best_any || flip_level(st_reg.prio_upper, st_reg.prio_lower, i)
             > best_lvl))
         begin
            best_any = 1'b1;
            best_lvl = flip_level(st_reg.prio_upper, st_reg.prio_lower, i);
            best_src = 3'(i);
         end
      end
      act_lvl = 2'd0;
      for (int l = 0; l < NLVL; l++)
      begin
         if (st_reg.active[l])
         begin
            act_lvl = 2'(l);
         end
      end
      // Equal or lower waits; higher preempts
      preempt_ok = best_any
                   && (st_reg.active == 4'h0 || best_lvl > act_lvl);
   end

   assign aw_hs = s_axi_awvalid && !st_reg.aw_got;
   assign w_hs = s_axi_wvalid && !st_reg.w_got;
   assign wr_fire = (st_reg.aw_got || aw_hs) && (st_reg.w_got || w_hs) && !st_reg.bvalid;
   assign rd_fire = s_axi_arvalid && !st_reg.rvalid;
   assign be0 = {8{st_reg.wstrb[0] | (w_hs & s_axi_wstrb[0])}};
   assign take_lvl = flip_level(st_reg.prio_upper, st_reg.prio_lower, int'(st_reg.vec_src));

   // Read mux
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      // Word index; address bits 1:0 are ignored
      unique case (s_axi_araddr[9:2])
         OFS_IRQ_ENABLE: rd_word[7:0] = st_reg.irq_enable & IE_IMPL_MASK;
         OFS_PRIO_LOWER: rd_word[5:0] = st_reg.prio_lower;
         OFS_PRIO_UPPER: rd_word[5:0] = st_reg.prio_upper;
         OFS_FLAGS: rd_word[5:0] = st_reg.pend | level_flags;
         OFS_ACTIVE: rd_word[3:0] = st_reg.active;
         OFS_STATUS: rd_word[2:0] = st_reg.stat;
         OFS_STAT_ENABLE: rd_word[2:0] = st_reg.stat_en;
         default: rd_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      logic [7:0] wa;
      logic [31:0] wd;
      logic [5:0] sw_clr;
      logic [2:0] ev, st_clr;
      st_next = st_reg;
      wa = aw_hs ? s_axi_awaddr[9:2] : st_reg.aw_addr;
      wd = w_hs ? s_axi_wdata : st_reg.wdata;
      sw_clr = 6'b000000;
      st_clr = 3'b000;
      clr_hw = 6'b000000;
      ev = 3'b000;
      if (aw_hs)
      begin
         st_next.aw_got = 1'b1;
         st_next.aw_addr = s_axi_awaddr[9:2];
      end
      if (w_hs)
      begin
         st_next.w_got = 1'b1;
         st_next.wdata = s_axi_wdata;
         st_next.wstrb = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         unique case (wa)
            OFS_IRQ_ENABLE: st_next.irq_enable = (wd[7:0] & IE_IMPL_MASK & be0)
                                                 | (st_reg.irq_enable & ~be0);
            OFS_PRIO_LOWER: st_next.prio_lower = (wd[5:0] & be0[5:0])
                                                 | (st_reg.prio_lower & ~be0[5:0]);
            OFS_PRIO_UPPER: st_next.prio_upper = (wd[5:0] & be0[5:0])
                                                 | (st_reg.prio_upper & ~be0[5:0]);
            OFS_FLAG_CLEAR: sw_clr = wd[5:0] & be0[5:0];
            OFS_STAT_CLEAR: st_clr = wd[2:0] & be0[2:0];
            OFS_STAT_ENABLE: st_next.stat_en = (wd[2:0] & be0[2:0])
                                               | (st_reg.stat_en & ~be0[2:0]);
            default: st_next.bresp = RESP_SLVERR;
         endcase
      end
      if (st_reg.bvalid && s_axi_bready)
      begin
         st_next.bvalid = 1'b0;
      end
      if (rd_fire)
      begin
         st_next.rvalid = 1'b1;
         st_next.rdata = rd_word;
         st_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (st_reg.rvalid && s_axi_rready)
      begin
         st_next.rvalid = 1'b0;
      end
      // Vector offer stands until the core acknowledges it
      if (st_reg.vec_valid && vec_ack)
      begin
         st_next.vec_valid = 1'b0;
         st_next.active[take_lvl] = 1'b1;
         clr_hw[0] = (st_reg.vec_src == 3'd0) && ext0_edge_mode;
         clr_hw[1] = (st_reg.vec_src == 3'd1);
         clr_hw[2] = (st_reg.vec_src == 3'd2) && ext1_edge_mode;
         clr_hw[3] = (st_reg.vec_src == 3'd3);
         ev[0] = 1'b1;
      end
      else if (!st_reg.vec_valid && preempt_ok && !handler_done)
      begin
         st_next.vec_valid = 1'b1;
         st_next.vec_src = best_src;
         st_next.vec_addr = 8'(VEC_BASE + 8'(best_src) * VEC_STEP);
      end
      // Done retires only the highest level, uncovering the preempted one
      if (handler_done && st_reg.active != 4'h0)
      begin
         st_next.active[act_lvl] = 1'b0;
         ev[1] = 1'b1;
      end
      else if (handler_done)
      begin
         ev[2] = 1'b1;
      end
      // Hardware set wins over any clear in the same cycle
      st_next.pend = (st_reg.pend & ~sw_clr & ~clr_hw) | raw_set;
      st_next.stat = (st_reg.stat & ~st_clr) | ev;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = !st_reg.aw_got;
   assign s_axi_wready = !st_reg.w_got;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign vec_valid = st_reg.vec_valid;
   assign vec_addr = st_reg.vec_addr;
   assign vec_src = st_reg.vec_src;
   assign irq = |(st_reg.stat & st_reg.stat_en);

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence take_s;
      vec_valid && vec_ack;
   endsequence

   // Offers only come from enabled, gated requests
   no_global_vec_a: assert property (!st_reg.irq_enable[BIT_GLOBAL_EN] && !vec_valid
      |=> !vec_valid)
      else $error("vector raised with global enable clear");
   no_req_vec_a: assert property (!vec_valid && req == 6'h00 |=> !vec_valid)
      else $error("vector raised with no enabled request");

   vec_addr_map_a: assert property ($rose(vec_valid)
      |-> vec_addr == 8'(VEC_BASE + 8'(vec_src) * VEC_STEP))
      else $error("vector address does not match source");
   vec_hold_a: assert property (vec_valid && !vec_ack |=> vec_valid && $stable(vec_src))
      else $error("vector offer dropped early");
   vec_addr_hold_a: assert property (vec_valid && !vec_ack |=> $stable(vec_addr))
      else $error("vector address changed during offer");

   take_active_a: assert property (take_s ##0 !handler_done
      |=> st_reg.active[$past(take_lvl)])
      else $error("accepted vector level not marked active");
   no_lower_vec_a: assert property ($rose(vec_valid) && $past(st_reg.active) != 4'h0
      |-> $past(best_lvl) > $past(act_lvl))
      else $error("equal or lower level vectored over active");
   done_retire_a: assert property (handler_done && st_reg.active != 4'h0 && !vec_ack
      |=> st_reg.active == ($past(st_reg.active) & ~(4'h1 << $past(act_lvl))))
      else $error("completion did not retire the top level");
   done_block_a: assert property (handler_done && !vec_valid |=> !vec_valid)
      else $error("vector raised in a completion cycle");

   // Flag clearing on vectoring differs by source
   t0_clear_a: assert property (take_s ##0 vec_src == 3'd1 && !timer0_overflow_flag
      |=> !st_reg.pend[1])
      else $error("timer 0 flag not cleared on vectoring");
   t1_clear_a: assert property (take_s ##0 vec_src == 3'd3 && !timer1_overflow_flag
      |=> !st_reg.pend[3])
      else $error("timer 1 flag not cleared on vectoring");
   ext_edge_clear_a: assert property (take_s ##0 vec_src == 3'd0 && ext0_edge_mode
      && !ext0_request_flag |=> !st_reg.pend[0])
      else $error("edge external flag not cleared on vectoring");
   ext_level_keep_a: assert property (take_s ##0 vec_src == 3'd0 && !ext0_edge_mode
      && st_reg.pend[0] && !wr_fire |=> st_reg.pend[0])
      else $error("level external flag cleared by hardware");
   sp_keep_a: assert property (st_reg.pend[4] && !st_reg.vec_valid && !(wr_fire)
      |=> st_reg.pend[4])
      else $error("serial flag cleared by hardware");

   irq_level_a: assert property (irq == |(st_reg.stat & st_reg.stat_en))
      else $error("interrupt output mismatch");

   // Bus answers stand until the master takes them
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
endmodule : flip_ctrl

// [tb/flip_cpu_model.sv]
// CPU core model: takes offered vectors and returns from handlers
`timescale 1ns/100ps
module flip_cpu_model
   import flip_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Vector side
   input wire logic vec_valid,
   input wire logic [7:0] vec_addr,
   output logic vec_ack,
   output logic handler_done,
   // Bench control
   input wire logic [3:0] ack_wait,
   input wire logic done_req,
   output logic [7:0] last_addr,
   output logic [7:0] taken
);
   logic [3:0] wait_reg;
   // Slow acks leave the offer standing for several cycles
   always_ff @(posedge aclk)
   begin
      handler_done <= done_req & aresetn;
      if (!aresetn)
      begin
         vec_ack <= 1'b0;
         wait_reg <= 4'h0;
         last_addr <= 8'h00;
         taken <= 8'h00;
      end
      else if (vec_valid && !vec_ack && wait_reg >= ack_wait)
      begin
         vec_ack <= 1'b1;
         wait_reg <= 4'h0;
         last_addr <= vec_addr;
         taken <= taken + 8'h01;
      end
      else
      begin
         vec_ack <= 1'b0;
         wait_reg <= vec_valid ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule : flip_cpu_model

// [tb/tb.sv]
// Self-checking bench for the interrupt priority controller
`timescale 1ns/100ps
`define CHK(n, e, g) \
   begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %0h got %0h", n, (e), (g)); end end
module tb
   import flip_pkg::*;
;
   typedef struct packed {logic [7:0] fl; logic [1:0] em; logic [7:0] vec;
      logic [5:0] left;} flip_row_s;
   flip_row_s rows [10] = '{'{8'h01, 2'h3, 8'h03, 6'h00}, '{8'h02, 2'h3, 8'h0B, 6'h00},
      '{8'h04, 2'h3, 8'h13, 6'h00}, '{8'h08, 2'h3, 8'h1B, 6'h00}, '{8'h10, 2'h3, 8'h23, 6'h10},
      '{8'h40, 2'h3, 8'h23, 6'h10}, '{8'h20, 2'h3, 8'h2B, 6'h20}, '{8'h80, 2'h3, 8'h2B, 6'h20},
      '{8'h01, 2'h0, 8'h03, 6'h01}, '{8'h04, 2'h0, 8'h13, 6'h04}};
   logic [7:0] zaddr [6] = '{8'hA8, 8'hB8, 8'hB7, 8'hC8, 8'hC0, 8'hD0};
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, done_req = 0;
   logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [7:0] fl = 0, last_addr, taken, t;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 0, ack_wait = 0;
   logic [1:0] em = 0, s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic vec_valid, vec_ack, handler_done, irq;
   logic [7:0] vec_addr;
   logic [2:0] vec_src;
   int bad_count = 0, checked = 0;
   always #12.5 aclk = ~aclk;
   flip_ctrl u_flip_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ext0_request_flag(fl[0]), .ext0_edge_mode(em[0]),
      .ext1_request_flag(fl[2]), .ext1_edge_mode(em[1]), .timer0_overflow_flag(fl[1]),
      .timer1_overflow_flag(fl[3]), .receive_done_flag(fl[4]), .transmit_done_flag(fl[6]),
      .timer2_overflow_flag(fl[5]), .timer2_external_flag(fl[7]), .vec_valid, .vec_addr,
      .vec_src, .vec_ack, .handler_done, .irq);
   flip_cpu_model u_flip_cpu_model (.aclk, .aresetn, .vec_valid, .vec_addr, .vec_ack,
      .handler_done, .ack_wait, .done_req, .last_addr, .taken);
   task automatic results();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic pl(input logic [7:0] m);
      fl <= m;
      @(posedge aclk);
      fl <= 8'h00;
      @(posedge aclk);
   endtask : pl
   task automatic wt(input logic [7:0] t0);
      while (taken === t0)
      begin
         @(posedge aclk);
      end
      repeat (2) @(posedge aclk);
   endtask : wt
   task automatic fin();
      done_req <= 1'b1;
      @(posedge aclk);
      done_req <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : fin
   initial
   begin
      #500000;
      bad_count++;
      results();
   end
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (zaddr[k])
      begin
         rd(zaddr[k]);
         `CHK("reset", 32'h0, rdat)
      end
      wr(8'h10, 32'h1);
      `CHK("unmapped", RESP_SLVERR, resp)
      rd(8'h10);
      `CHK("unmapped rd", RESP_SLVERR, resp)
      wr(OFS_IRQ_ENABLE, 32'hFF);
      rd(OFS_IRQ_ENABLE);
      `CHK("enable", 32'(IE_IMPL_MASK), rdat)
      // Global enable off: pending request must wait
      wr(OFS_IRQ_ENABLE, 32'h3F);
      pl(8'h02);
      repeat (10) @(posedge aclk);
      `CHK("gated", 8'h00, taken)
      wr(OFS_IRQ_ENABLE, 32'hBF);
      wt(8'h00);
      `CHK("ungated", 8'h0B, last_addr)
      fin();
      for (int i = 0; i < 10; i++)
      begin
         em <= rows[i].em;
         ack_wait <= 4'(i % 3);
         t = taken;
         pl(rows[i].fl);
         wt(t);
         `CHK("vector", rows[i].vec, last_addr)
         `CHK("source", 3'(rows[i].vec >> 3), vec_src)
         rd(OFS_FLAGS);
         `CHK("flags", rows[i].left, rdat[5:0])
         wr(OFS_FLAG_CLEAR, 32'(rows[i].left));
         fin();
      end
      // All six at once at one level come out in polling order
      em <= 2'h3;
      pl(8'h3F);
      for (int k = 0; k < 6; k++)
      begin
         wt(taken - 8'h01);
         `CHK("poll", VEC_BASE + VEC_STEP * 8'(k), last_addr)
         wr(OFS_FLAG_CLEAR, 32'h1 << k);
         t = taken;
         fin();
         if (k < 5) wt(t);
      end
      wr(OFS_PRIO_LOWER, 32'h09);
      wr(OFS_PRIO_UPPER, 32'h0A);
      wr(OFS_STAT_CLEAR, 32'h7);
      wr(OFS_STAT_ENABLE, 32'h1);
      `CHK("irq idle", 1'b0, irq)
      t = taken;
      pl(8'h01);
      wt(t);
      `CHK("lvl1", 8'h03, last_addr)
      rd(OFS_ACTIVE);
      `CHK("act1", 32'h2, rdat)
      `CHK("irq set", 1'b1, irq)
      t = taken;
      pl(8'h08);
      wt(t);
      `CHK("preempt", 8'h1B, last_addr)
      rd(OFS_ACTIVE);
      `CHK("nested", 32'hA, rdat)
      t = taken;
      pl(8'h02);
      repeat (10) @(posedge aclk);
      `CHK("held", t, taken)
      fin();
      wt(t);
      `CHK("resumed", 8'h0B, last_addr)
      rd(OFS_ACTIVE);
      `CHK("act2", 32'h6, rdat)
      fin();
      rd(OFS_ACTIVE);
      `CHK("restore", 32'h2, rdat)
      fin();
      wr(OFS_STAT_ENABLE, 32'h0);
      `CHK("irq mask", 1'b0, irq)
      wr(OFS_STAT_ENABLE, 32'h1);
      `CHK("irq unmask", 1'b1, irq)
      wr(OFS_STAT_CLEAR, 32'h7);
      `CHK("irq clear", 1'b0, irq)
      // Completion with nothing in service is only flagged
      fin();
      rd(OFS_STATUS);
      `CHK("spurious", 32'h4, rdat)
      // Mid-run reset drops enables and any offer
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("reset offer", 1'b0, vec_valid)
      rd(OFS_IRQ_ENABLE);
      `CHK("reset enable", 32'h0, rdat)
      results();
   end
endmodule : tb
